// ---- rtl/hmp_device.sv ----
/*
 Device end of the host memory port: pin sync, 8/16-bit decode, DMA bus master
 toward on-chip RAM. Assumes the DMA bus grants by mem_ack, a running clock,
 and an arbiter that delays the CPU when MEM_HOST_WIN_OUT is high.
*/
// Operation
// R1: Strap high 16-bit, low 8-bit
// R2: 8-bit bus, two bytes per word
// R3: Address, data, control registers in 8-bit
// R4: Autoincrement or random address transfers
// R5: Every access starts a DMA cycle; code: only 16-bit accesses and 8-bit data high bytes
// R6: Transfers continue during emulation halt
// R7: 16-bit mode uses 18-bit address bus
// R8: 16-bit bidirectional data bus
// R9: Ready low stalls until DMA done
// R10: Host starts with select and strobe
// R11: No control register in 16-bit mode
// R12: Host wins contention, CPU waits one
// R13: Host pins synchronized to device clock
// R14: No host access during reset
// R15: Host address map with reserved gaps
// R16: Keeper on in 16-bit, bit-controlled else
// R17: Reserved addresses harmless, read undefined
`timescale 1ns/1ps
`include "hmp_defs.svh"
module hmp_device import hmp_pkg::*; (
   input wire logic SYS_CLK_IN,                 // Device clock
   input wire logic RESETN_IN,                  // Sync reset, active low
   hmp_if.device HP,                            // Host pins
   input wire logic EMU_HALT_IN,                // CPU halted by emulation
   input wire logic [`HMP_CTRL_W-1:0] CPU_CTRL_WDATA_IN, // CPU control write data
   input wire logic CPU_CTRL_WE_IN,             // CPU control write strobe
   output logic [`HMP_CTRL_W-1:0] CPU_CTRL_RDATA_OUT, // Control register to CPU
   output logic MEM_REQ_OUT,                    // DMA request
   output logic MEM_WE_OUT,                     // DMA write
   output logic [17:0] MEM_ADDR_OUT,            // DMA address
   output logic [15:0] MEM_WDATA_OUT,           // DMA write data
   input wire logic MEM_ACK_IN,                 // DMA done
   input wire logic [15:0] MEM_RDATA_IN,        // DMA read data
   output logic MEM_HOST_WIN_OUT                // Host priority over CPU
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int SW = 42;
   logic [SW-1:0] pin_raw, s1_q, s2_q;          // Raw, first, second stage
   assign pin_raw = {HP.host_width_select, HP.host_chip_select_n,
      HP.host_data_strobe_a_n, HP.host_data_strobe_b_n, HP.host_read_write,
      HP.byte_half_select, HP.host_register_select, HP.host_address_bus, HP.hd_wire};
   // Two flops on every pin; only s2_q is read further on
   always_ff @(posedge SYS_CLK_IN) begin
      s1_q <= pin_raw; // R13
      s2_q <= s1_q;
   end
   logic wide, cs_n, sa_n, sb_n, rnw, bh;
   logic [1:0] rsel;
   logic [17:0] ha;
   logic [15:0] hd;
   assign {wide, cs_n, sa_n, sb_n, rnw, bh, rsel, ha, hd} = s2_q;
   // Strobe active: select low and strobes combined as in the usual xor form
   logic strobe, strobe_q, strobe_rise;
   assign strobe = ~cs_n & (sa_n ^ sb_n);       // R10
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) strobe_q <= 1'b0;
      else strobe_q <= strobe;
   end
   assign strobe_rise = strobe & ~strobe_q;
   // ----------------------------------------
   // Host registers
   // ----------------------------------------
   logic [17:0] addr_q;                         // Host address register
   logic [15:0] data_q;                         // Host data register
   logic [`HMP_CTRL_W-1:0] ctrl_q;              // Shared control register
   logic [7:0] lo_hold_q;                       // First byte of a word write
   hmp_dev_state_t st_q;
   logic inc_q;                                 // Autoincrement after this cycle
   logic start;                                 // Start a DMA cycle
   logic byte_access;
   // 8-bit mode: a DMA cycle fires on the second (high) byte only
   assign byte_access = ~wide & strobe_rise;    // R1
   assign start = strobe_rise & (wide | ((rsel == `HMP_REG_DATA ||
      rsel == `HMP_REG_DATA_INC) & bh));        // R5
   // Address register: 16-bit mode takes the pin address each access
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) addr_q <= 18'h00000;
      else if (wide & strobe_rise) addr_q <= ha;          // R7
      else if (byte_access & rsel == `HMP_REG_ADDR & ~rnw) begin
         if (bh) addr_q[15:8] <= hd[7:0];                 // R2
         else addr_q[7:0] <= hd[7:0];
      end else if (st_q == HMP_DONE & ~strobe & inc_q) // Once, on leaving DONE
         addr_q <= addr_q + 18'h00001;                    // R4
   end
   // Byte collect for 8-bit writes
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) lo_hold_q <= 8'h00;
      else if (byte_access & ~bh & ~rnw) lo_hold_q <= hd[7:0]; // R2
   end
   // Control register: host in 8-bit only, CPU always; host wins same cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) ctrl_q <= `HMP_CTRL_RESET;
      else if (byte_access & rsel == `HMP_REG_CTRL & ~rnw & ~bh)
         ctrl_q <= hd[7:0];                                 // R3 R11
      else if (CPU_CTRL_WE_IN) ctrl_q <= CPU_CTRL_WDATA_IN; // R3
   end
   assign CPU_CTRL_RDATA_OUT = ctrl_q;
   // ----------------------------------------
   // DMA sequencer
   // ----------------------------------------
   logic in_map;
   // Reserved regions never reach memory
   assign in_map = (addr_q >= `HMP_SCRATCH_LO && addr_q <= `HMP_DARAM_HI) ||
      (addr_q >= `HMP_DARAM2_LO && addr_q <= `HMP_DARAM2_HI) ||
      (addr_q >= `HMP_SARAM_LO && addr_q <= `HMP_SARAM_HI) ||
      (addr_q >= `HMP_SARAM2_LO); // R15
   logic go_q;                                  // Start delayed for address load
   logic rnw_q;
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) go_q <= 1'b0;
      else go_q <= start;
   end
   // Emulation halt deliberately not an input term: host keeps service
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         st_q <= HMP_IDLE;
         inc_q <= 1'b0;
         rnw_q <= 1'b1;
      end else begin
         case (st_q)
            HMP_IDLE: if (go_q) begin                      // R6
               st_q <= HMP_DMA;
               inc_q <= ~wide & (rsel == `HMP_REG_DATA_INC);
               rnw_q <= rnw;
            end
            HMP_DMA: if (MEM_ACK_IN | ~in_map) st_q <= HMP_DONE; // R17
            HMP_DONE: if (~strobe) st_q <= HMP_IDLE;
            default: st_q <= HMP_IDLE;
         endcase
      end
   end
   assign MEM_REQ_OUT = (st_q == HMP_DMA) & in_map; // R5
   assign MEM_HOST_WIN_OUT = MEM_REQ_OUT;           // R12
   assign MEM_WE_OUT = ~rnw_q;
   assign MEM_ADDR_OUT = addr_q;
   // Write data: full word in 16-bit, held low byte plus high in 8-bit
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) MEM_WDATA_OUT <= 16'h0000;
      else if (start) MEM_WDATA_OUT <= wide ? hd : {hd[7:0], lo_hold_q}; // R8
   end
   // Read data latched on ack; reserved reads leave stale value
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) data_q <= 16'h0000;
      else if (st_q == HMP_DMA & MEM_ACK_IN & in_map & rnw_q) data_q <= MEM_RDATA_IN;
   end
   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Ready low from strobe to DMA done; go_q covers the address-load cycle before DMA starts
   assign HP.host_ready = ~((strobe & (start | go_q)) | st_q == HMP_DMA |
      (st_q == HMP_IDLE & go_q)); // R9
   // 8-bit reads: low byte first, then high byte, from last fetched word
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) HP.hd_dev <= 16'h0000;
      else if (wide) HP.hd_dev <= data_q;
      else if (rsel == `HMP_REG_CTRL) HP.hd_dev <= {8'h00, ctrl_q};
      else if (rsel == `HMP_REG_ADDR) HP.hd_dev <= {8'h00, bh ? addr_q[15:8] : addr_q[7:0]};
      else HP.hd_dev <= {8'h00, bh ? data_q[15:8] : data_q[7:0]};
   end
   // Enable registered so it rises together with settled hd_dev, never ahead
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) HP.hd_dev_oe <= 1'b0;
      else HP.hd_dev_oe <= strobe & rnw & (st_q != HMP_DMA) & ~go_q; // R8
   end
   // Keeper always on for wide hosts
   assign HP.hd_keeper_en = wide | ctrl_q[`HMP_KEEPER_BIT]; // R16
endmodule // hmp_device

// ---- shared/hmp_defs.svh ----
/*
 Timing counts, address map bounds and widths for the host memory port.
 Assumes inclusion by bare name from shared/ on the include path.
*/
`ifndef HMP_DEFS_SVH
`define HMP_DEFS_SVH
`define HMP_ADDR_W 18
`define HMP_DATA_W 16
`define HMP_SCRATCH_LO 18'h00060
`define HMP_SCRATCH_HI 18'h0007f
`define HMP_DARAM_LO 18'h00080
`define HMP_DARAM_HI 18'h07fff
`define HMP_DARAM2_LO 18'h18000
`define HMP_DARAM2_HI 18'h1ffff
`define HMP_SARAM_LO 18'h28000
`define HMP_SARAM_HI 18'h2ffff
`define HMP_SARAM2_LO 18'h38000
`define HMP_SARAM2_HI 18'h3ffff
`define HMP_REG_ADDR 2'h0
`define HMP_REG_DATA_INC 2'h1
`define HMP_REG_DATA 2'h2
`define HMP_REG_CTRL 2'h3
`define HMP_CTRL_W 8
`define HMP_CTRL_RESET 8'h00
`define HMP_KEEPER_BIT 2
`define HMP_PHASE_END 4'h5
`define HMP_WAIT_MIN 4'h6
`define HMP_ADDR_GAP_END 4'hb
`endif

// ---- shared/hmp_pkg.sv ----
/*
 Types shared by both ends of the host memory port.
 Assumes hmp_defs.svh is on the include path.
*/
package hmp_pkg;
   // Device end states
   typedef enum logic [1:0] {HMP_IDLE, HMP_DMA, HMP_DONE} hmp_dev_state_t;
   // Host end states
   typedef enum logic [2:0] {HMH_IDLE, HMH_BYTE0, HMH_GAP, HMH_BYTE1, HMH_WAIT,
                             HMH_END} hmp_host_state_t;
endpackage

// ---- shared/hmp_if.sv ----
/*
 Pin bundle between an external host and the device's host memory port.
 Resolves the shared data wire here from the two drive enables.
*/
`timescale 1ns/1ps
interface hmp_if;
   logic host_width_select;         // Strap, 1 = 16-bit host
   logic host_chip_select_n;        // Chip select, active low
   logic host_data_strobe_a_n;      // Strobe a, active low
   logic host_data_strobe_b_n;      // Strobe b, active low
   logic host_read_write;           // 1 = read, 0 = write
   logic byte_half_select;          // 8-bit mode: 1 = high byte
   logic [1:0] host_register_select;// 8-bit mode register select
   logic [17:0] host_address_bus;   // 16-bit mode address
   logic [15:0] hd_host;            // Host drive value
   logic hd_host_oe;                // Host drives data
   logic [15:0] hd_dev;             // Device drive value
   logic hd_dev_oe;                 // Device drives data
   logic hd_keeper_en;              // Device keeper enable
   logic [15:0] hd_wire;            // Resolved wire level
   logic host_ready;                // Device ready, high = done
   // Resolved data as each end sees it
   // Nobody driving shows the inverse, so a late or early sample shows up
   assign hd_wire = hd_dev_oe ? hd_dev : (hd_host_oe ? hd_host : ~hd_host);
   modport device (input host_width_select, host_chip_select_n, host_data_strobe_a_n,
      host_data_strobe_b_n, host_read_write, byte_half_select, host_register_select,
      host_address_bus, hd_wire, output hd_dev, hd_dev_oe, hd_keeper_en, host_ready);
   modport host (output host_width_select, host_chip_select_n, host_data_strobe_a_n,
      host_data_strobe_b_n, host_read_write, byte_half_select, host_register_select,
      host_address_bus, hd_host, hd_host_oe, input hd_wire, host_ready);
endinterface // hmp_if

// ---- rtl/hmp_host.sv ----
/*
 Host end: turns user word requests into pin cycles, in 8-bit or 16-bit form.
 Assumes the device end answers on host_ready; reset held until device ready.
*/
`timescale 1ns/1ps
`include "hmp_defs.svh"
module hmp_host import hmp_pkg::*; (
   input wire logic SYS_CLK_IN,          // Host clock
   input wire logic RESETN_IN,           // Sync reset, active low
   hmp_if.host HP,                       // Pins toward device
   input wire logic WIDE_IN,             // Strap value to drive
   input wire logic REQ_IN,              // Start a word transfer
   input wire logic RNW_IN,              // 1 = read
   input wire logic AUTOINC_IN,          // 8-bit: use autoincrement data register
   input wire logic [17:0] ADDR_IN,      // Address; 8-bit random access sends ADDR_IN[15:0] as bytes
   input wire logic [15:0] WDATA_IN,     // Write word
   output logic BUSY_OUT,                // Transfer in progress
   output logic DONE_OUT,                // One-cycle done
   output logic [15:0] RDATA_OUT         // Read word
);
   // ----------------------------------------
   // Ready sync and state
   // ----------------------------------------
   logic rdy1_q, rdy2_q;
   always_ff @(posedge SYS_CLK_IN) begin
      rdy1_q <= HP.host_ready;
      rdy2_q <= rdy1_q;
   end
   hmp_host_state_t st_q;
   logic [3:0] cnt_q;                    // Strobe hold, covers device sync
   logic rnw_q;
   logic [15:0] wd_q;
   logic aph_q;                          // 8-bit: address bytes go out first
   logic [15:0] byte_src;                // Word whose bytes go out in 8-bit mode
   // Strap driven straight through
   assign HP.host_width_select = WIDE_IN; // R1
   assign HP.host_data_strobe_b_n = 1'b1;
   assign HP.host_read_write = rnw_q & ~aph_q; // Address bytes are writes
   // Select and strobe only while a byte or word phase runs; BYTE1 ends in a gap
   assign HP.host_chip_select_n = ~(st_q == HMH_BYTE0 ||
      (st_q == HMH_BYTE1 && cnt_q <= `HMP_PHASE_END) || st_q == HMH_WAIT); // R10
   assign HP.host_data_strobe_a_n = HP.host_chip_select_n; // R10
   assign HP.byte_half_select = (st_q == HMH_BYTE1) | (st_q == HMH_WAIT & ~WIDE_IN); // R2
   assign HP.host_register_select = aph_q ? `HMP_REG_ADDR :
      (AUTOINC_IN ? `HMP_REG_DATA_INC : `HMP_REG_DATA); // R3
   assign HP.host_address_bus = ADDR_IN;
   assign byte_src = aph_q ? ADDR_IN[15:0] : wd_q;
   assign HP.hd_host = WIDE_IN ? wd_q : {8'h00, (HP.byte_half_select ? byte_src[15:8] :
      byte_src[7:0])};
   assign HP.hd_host_oe = (~rnw_q | aph_q) & ~HP.host_chip_select_n;
   assign BUSY_OUT = st_q != HMH_IDLE;
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // In 8-bit the low byte reads the previously fetched word; sequential use assumed
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         st_q <= HMH_IDLE; // R14
         cnt_q <= 4'h0;
         rnw_q <= 1'b1;
         aph_q <= 1'b0;
         wd_q <= 16'h0000;
         DONE_OUT <= 1'b0;
         RDATA_OUT <= 16'h0000;
      end else begin
         DONE_OUT <= 1'b0;
         cnt_q <= cnt_q + 4'h1;
         case (st_q)
            HMH_IDLE: if (REQ_IN) begin
               rnw_q <= RNW_IN;
               wd_q <= WDATA_IN;
               cnt_q <= 4'h0;
               // Random access loads the address register first; autoincrement skips it
               aph_q <= ~WIDE_IN & ~AUTOINC_IN; // R4
               st_q <= WIDE_IN ? HMH_WAIT : HMH_BYTE0;
            end
            HMH_BYTE0: if (cnt_q == `HMP_PHASE_END) begin
               RDATA_OUT[7:0] <= HP.hd_wire[7:0];
               cnt_q <= 4'h0;
               st_q <= HMH_GAP;
            end
            HMH_GAP: if (cnt_q == `HMP_PHASE_END) begin
               cnt_q <= 4'h0;
               st_q <= aph_q ? HMH_BYTE1 : HMH_WAIT;
            end
            // High address byte, then a gap so the device sees the strobe drop
            HMH_BYTE1: if (cnt_q == `HMP_ADDR_GAP_END) begin
               aph_q <= 1'b0;
               cnt_q <= 4'h0;
               st_q <= HMH_BYTE0;
            end
            HMH_WAIT: if (cnt_q >= `HMP_WAIT_MIN && rdy2_q) begin // R9
               if (WIDE_IN) RDATA_OUT <= HP.hd_wire;
               else RDATA_OUT[15:8] <= HP.hd_wire[7:0];
               cnt_q <= 4'h0;
               st_q <= HMH_END;
            end
            HMH_END: if (cnt_q == `HMP_PHASE_END) begin
               DONE_OUT <= 1'b1;
               st_q <= HMH_IDLE;
            end
            default: st_q <= HMH_IDLE;
         endcase
      end
   end
endmodule // hmp_host

// ---- bench/hmp_assertions.sv ----
/*
 Checker for the pins between host end and device end of the host memory port.
 Assumes one clock for both ends and the interface signals wired in by name.
*/
`timescale 1ns/1ps
module hmp_assertions (
   input wire logic SYS_CLK_IN, // Shared clock
   input wire logic RESETN_IN, // Sync reset, active low
   input wire logic host_width_select,
   input wire logic host_chip_select_n,
   input wire logic host_data_strobe_a_n,
   input wire logic host_data_strobe_b_n,
   input wire logic host_read_write,
   input wire logic [17:0] host_address_bus,
   input wire logic hd_host_oe,
   input wire logic [15:0] hd_dev,
   input wire logic hd_dev_oe,
   input wire logic hd_keeper_en,
   input wire logic host_ready
);
   // -------------------------------------------------
   // Access strobe: select low and exactly one strobe low
   // -------------------------------------------------
   logic strb;
   assign strb = !host_chip_select_n && (host_data_strobe_a_n ^ host_data_strobe_b_n);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   keeper_when_wide_a: assert property (host_width_select |-> hd_keeper_en)
      else $error("keeper off in wide mode");
   no_bus_fight_a: assert property (!(hd_dev_oe && hd_host_oe))
      else $error("both ends drive the data bus");
   drive_on_read_a: assert property ($rose(hd_dev_oe) |-> host_read_write && strb)
      else $error("device drives outside a read");
   read_data_holds_a: assert property (host_ready && $past(host_ready) && hd_dev_oe
      && $past(hd_dev_oe) && strb |-> $stable(hd_dev))
      else $error("read data moved while held");
   stall_bounded_a: assert property (!host_ready |-> ##[1:60] host_ready)
      else $error("ready held low too long");
   sync_delay_a: assert property ($rose(strb) |-> host_ready [*2])
      else $error("ready dropped before sync");
   idle_ready_a: assert property (!strb [*5] |-> host_ready)
      else $error("stall without an access");
   addr_hold_a: assert property (strb && $past(strb) && host_width_select
      |-> $stable(host_address_bus))
      else $error("address moved during access");
   stall_cause_a: assert property ($fell(host_ready) |-> strb && $past(strb, 2))
      else $error("stall not caused by a held strobe");
   // Main scenarios reached
   wide_read_c: cover property ($rose(host_ready) && host_width_select && host_read_write);
   byte_write_c: cover property ($rose(host_ready) && !host_width_select && !host_read_write);
   long_stall_c: cover property (!host_ready [*4]);
   byte_read_c: cover property ($rose(host_ready) && !host_width_select && host_read_write);
endmodule // hmp_assertions

// ---- bench/host_memory_port_bench.sv ----
/*
 Self-checking bench: host end and device end joined by the pin interface,
 with a bench memory on the DMA side that acks after a random stall.
 Assumes hmp_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "hmp_defs.svh"
module host_memory_port_bench;
   logic clk, rst_n, emu_halt, ctrl_we, wide, req, rnw, autoinc, busy, done;
   logic mem_req, mem_we, mem_ack, host_win;
   logic [7:0] ctrl_wd, ctrl_rd;
   logic [17:0] addr, mem_addr, a;
   logic [15:0] wdata, rdata, mem_wdata, mem_rdata, d;
   logic [15:0] mem [bit [17:0]]; // Bench memory behind the DMA bus
   logic [15:0] exp_mem [bit [17:0]]; // What the host should read back
   logic [17:0] q[$];
   logic [17:0] rsv[5] = '{18'h00000, 18'h0005f, 18'h08000, 18'h20000, 18'h37fff};
   int fails, tests_run, n_mem, n0;
   hmp_if hp();
   hmp_device hmp_device_i (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .HP(hp),
      .EMU_HALT_IN(emu_halt), .CPU_CTRL_WDATA_IN(ctrl_wd), .CPU_CTRL_WE_IN(ctrl_we),
      .CPU_CTRL_RDATA_OUT(ctrl_rd), .MEM_REQ_OUT(mem_req), .MEM_WE_OUT(mem_we),
      .MEM_ADDR_OUT(mem_addr), .MEM_WDATA_OUT(mem_wdata), .MEM_ACK_IN(mem_ack),
      .MEM_RDATA_IN(mem_rdata), .MEM_HOST_WIN_OUT(host_win));
   hmp_host hmp_host_i (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .HP(hp), .WIDE_IN(wide),
      .REQ_IN(req), .RNW_IN(rnw), .AUTOINC_IN(autoinc), .ADDR_IN(addr), .WDATA_IN(wdata),
      .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata));
   hmp_assertions hmp_assertions_i (.SYS_CLK_IN(clk), .RESETN_IN(rst_n),
      .host_width_select(hp.host_width_select), .host_chip_select_n(hp.host_chip_select_n),
      .host_data_strobe_a_n(hp.host_data_strobe_a_n),
      .host_data_strobe_b_n(hp.host_data_strobe_b_n), .host_read_write(hp.host_read_write),
      .host_address_bus(hp.host_address_bus), .hd_host_oe(hp.hd_host_oe), .hd_dev(hp.hd_dev),
      .hd_dev_oe(hp.hd_dev_oe), .hd_keeper_en(hp.hd_keeper_en), .host_ready(hp.host_ready));
   // -------------------------------------------------
   // Clock, watchdog and shared tasks
   // -------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Whole run is well under 5000 cycles; six times that means a hang
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      give_verdict();
   end
   task automatic give_verdict();
      if (fails == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Strap only changes under reset, so each mode starts clean
   task automatic do_reset(input logic w);
      wide = w;
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
   endtask
   // One word transfer from the host user side, bounded wait on done
   task automatic xfer(input logic r, input logic ai, input logic [17:0] ad,
                       input logic [15:0] wd);
      int k;
      @(negedge clk);
      req = 1'b1;
      rnw = r;
      autoinc = ai;
      addr = ad;
      wdata = wd;
      @(negedge clk);
      req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      if (k >= 400) chk("done_seen", 18'h1, 18'h0);
   endtask
   task automatic cpu_ctrl(input logic [7:0] v);
      @(negedge clk);
      ctrl_wd = v;
      ctrl_we = 1'b1;
      @(negedge clk);
      ctrl_we = 1'b0;
      @(negedge clk);
   endtask
   function automatic logic [17:0] rnd_addr(input int lo, input int hi);
      return 18'(lo + $urandom % (hi - lo + 1));
   endfunction
   // -------------------------------------------------
   // DMA-side memory: random stall stretches host_ready low
   // -------------------------------------------------
   always @(negedge clk) begin
      mem_ack <= 1'b0;
      if (rst_n) chk("host_win", {17'h0, mem_req}, {17'h0, host_win});
      if (mem_req === 1'b1 && !mem_ack && $urandom % 3 == 0) begin
         mem_ack <= 1'b1;
         n_mem++;
         if (mem_we) mem[mem_addr] = mem_wdata;
         else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0;
      end
   end
   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      rst_n = 1'b0; emu_halt = 1'b0; ctrl_we = 1'b0; ctrl_wd = 8'h00; wide = 1'b1;
      req = 1'b0; rnw = 1'b0; autoinc = 1'b0; addr = 18'h0; wdata = 16'h0;
      void'($urandom(49));
      do_reset(1'b1);
      chk("ctrl_reset", 18'h0, {10'h0, ctrl_rd});
      chk("keeper_wide", 18'h1, {17'h0, hp.hd_keeper_en});
      // Region edges first, then random places in DARAM, in DARAM2 or SARAM, and in SARAM2
      q = '{`HMP_SCRATCH_LO, `HMP_SCRATCH_HI, `HMP_DARAM_LO, `HMP_DARAM2_HI,
            `HMP_SARAM_LO, `HMP_SARAM2_HI};
      repeat (4) q.push_back(rnd_addr(`HMP_DARAM_LO, `HMP_DARAM_HI));
      repeat (4) q.push_back(rnd_addr(`HMP_DARAM2_LO, `HMP_SARAM_HI) | 18'h08000);
      repeat (4) q.push_back(rnd_addr(`HMP_SARAM2_LO, `HMP_SARAM2_HI));
      foreach (q[i]) begin
         d = 16'($urandom);
         exp_mem[q[i]] = d;
         emu_halt = 1'($urandom % 2);
         n0 = n_mem;
         xfer(1'b0, 1'b0, q[i], d);
         chk("w16_dma", 18'h1, 18'(n_mem - n0));
         chk("w16_mem", {2'h0, d}, {2'h0, mem[q[i]]});
      end
      foreach (q[i]) begin
         xfer(1'b1, 1'b0, q[i], 16'h0);
         chk("r16_data", {2'h0, exp_mem[q[i]]}, {2'h0, rdata});
      end
      // Reserved holes: no DMA cycle, access still completes
      foreach (rsv[i]) begin
         n0 = n_mem;
         xfer(1'b0, 1'b0, rsv[i], 16'ha5c3);
         xfer(1'b1, 1'b0, rsv[i], 16'h0);
         chk("rsv_no_dma", 18'h0, 18'(n_mem - n0));
      end
      // Byte-wide host: keeper follows the control bit
      do_reset(1'b0);
      chk("keeper_off", 18'h0, {17'h0, hp.hd_keeper_en});
      cpu_ctrl(8'h04);
      chk("ctrl_cpu", 18'h4, {10'h0, ctrl_rd});
      chk("keeper_on", 18'h1, {17'h0, hp.hd_keeper_en});
      cpu_ctrl(8'h00);
      // Four random writes, then a run of sequential ones
      for (int i = 0; i < 8; i++) begin
         // Fifth write reuses the last random address, the rest step on by one
         a = (i < 4) ? rnd_addr(`HMP_DARAM_LO, `HMP_DARAM_HI - 8) :
            ((i == 4) ? a : a + 18'h1);
         d = 16'($urandom);
         n0 = n_mem;
         xfer(1'b0, 1'(i >= 4), a, d);
         chk("w8_dma", 18'h1, 18'(n_mem - n0));
         chk("w8_mem", {2'h0, d}, {2'h0, mem[a]});
      end
      // Low byte comes from the previous fetch, so the second read is whole
      xfer(1'b1, 1'b0, a, 16'h0);
      xfer(1'b1, 1'b0, a, 16'h0);
      chk("r8_data", {2'h0, d}, {2'h0, rdata});
      give_verdict();
   end
endmodule // host_memory_port_bench
